// >>> shared/dqd_pkg.sv
// Shared constants, codes and carriers for the DAC input frame decoder.
package dqd_pkg;

  // Frame lengths in link clock edges, without and with the check code.
  localparam int FRAME_BITS = 24;
  localparam int PEC_FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] LAST_PLAIN_BIT = 6'h17;
  localparam logic [5:0] LAST_PEC_BIT = 6'h1f;
  localparam logic [5:0] CNT_SAT = 6'h20;

  // Channel and payload geometry.
  localparam int CHANNELS = 4;
  localparam int WORD_W = 16;
  localparam int CTRL_DATA_W = 13;

  // Values after reset of the per-channel banks.
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'hffff;
  localparam logic [15:0] OFFSET_RST = 16'h8000;
  localparam logic [15:0] CLEAR_RST = 16'h0000;

  // Position of the clear-enable flag inside a channel control payload.
  localparam int CLR_EN_BIT = 2;

  // Register-select codes carried in the frame.
  typedef enum logic [2:0] {
    SEL_DATA = 3'h0,
    SEL_GAIN = 3'h2,
    SEL_GAIN_ALL = 3'h3,
    SEL_OFFS = 3'h4,
    SEL_OFFS_ALL = 3'h5,
    SEL_CLEAR = 3'h6,
    SEL_CTRL = 3'h7
  } dqd_sel_e;

  // Control register group codes carried in payload bits 15 to 13.
  typedef enum logic [2:0] {
    CTL_SLEW = 3'h0,
    CTL_MAIN = 3'h1,
    CTL_CHAN = 3'h2,
    CTL_SUPPLY = 3'h3,
    CTL_SOFT = 3'h4
  } dqd_ctl_e;

  // One decoded 24-bit frame, most significant field first.
  typedef struct packed {
    logic rw;
    logic [1:0] dev_addr;
    logic [2:0] reg_sel;
    logic [1:0] chan;
    logic [15:0] payload;
  } dqd_frame_s;

  // A control register write passed on to the further decode.
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] chan;
    logic [12:0] data;
  } dqd_ctrl_s;

endpackage : dqd_pkg

// >>> hw/dqd_chan_bank.sv
// Bank of per-channel 16-bit registers with write and force ports.
`timescale 1ns/100ps
module dqd_chan_bank #(
  parameter int CH = 4,
  parameter int W = 16,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port, one shared word for all enabled channels.
  input wire logic [CH-1:0] wr_en_i,
  input wire logic [W-1:0] wr_data_i,
  // Force port, a separate word per channel, wins over the write port.
  input wire logic [CH-1:0] force_en_i,
  input wire logic [CH-1:0][W-1:0] force_data_i,
  // Registered contents.
  output logic [CH-1:0][W-1:0] q_o
);

  // Every channel loads independently; a broadcast simply enables all of them.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < CH; i++) begin
      if (rst_i) begin
        q_o[i] <= RST_VAL[W-1:0];
      end else if (force_en_i[i]) begin
        q_o[i] <= force_data_i[i];
      end else if (wr_en_i[i]) begin
        q_o[i] <= wr_data_i;
      end
    end
  end

endmodule : dqd_chan_bank

// >>> hw/dqd_frame_decode.sv
// Serial input frame decoder steering payloads into the channel register banks.
`timescale 1ns/100ps
module dqd_frame_decode #(
  parameter int CH = 4,
  parameter int W = 16
) (
  // System clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link, clocked by the host.
  input wire logic link_sclk_i,
  input wire logic sync_n_i,
  input wire logic sdin_i,
  // Static pins.
  input wire logic pec_en_i,
  input wire logic addr_strap_hi_i,
  input wire logic addr_strap_lo_i,
  input wire logic clear_i,
  // Channel registers.
  output logic [CH-1:0][W-1:0] chan_code_o,
  output logic [CH-1:0][W-1:0] gain_trim_o,
  output logic [CH-1:0][W-1:0] offset_trim_o,
  output logic [CH-1:0][W-1:0] clear_value_o,
  output logic [CH-1:0] clear_en_o,
  // Control register writes for the further decode.
  output logic ctrl_wr_o,
  output dqd_pkg::dqd_ctrl_s ctrl_o
);

  // Link domain state.
  logic [dqd_pkg::CNT_W-1:0] bit_cnt_q;
  logic [dqd_pkg::FRAME_BITS-2:0] shift_q;
  logic [dqd_pkg::FRAME_BITS-1:0] word_q;
  logic plain_tgl_q;
  logic pec_tgl_q;

  // System domain state.
  logic [2:0] plain_sync_q;
  logic [2:0] pec_sync_q;
  logic plain_seen_q;
  logic pec_seen_q;
  logic [2:0] pec_pin_q;
  logic pec_mode_q;
  logic [2:0] clr_pin_q;
  logic clr_act_q;
  logic [2:0][1:0] strap_pin_q;
  logic [1:0] strap_q;
  logic [CH-1:0] clr_en_q;
  logic ctrl_wr_q;
  dqd_pkg::dqd_ctrl_s ctrl_q;

  // Decode signals.
  logic plain_evt;
  logic pec_evt;
  logic frame_evt;
  dqd_pkg::dqd_frame_s fr;
  logic addr_match;
  logic wr_ok;
  logic [CH-1:0] chan_hot;
  logic [CH-1:0] data_we;
  logic [CH-1:0] gain_we;
  logic [CH-1:0] offs_we;
  logic [CH-1:0] clrv_we;
  logic [CH-1:0] force_en;

  // Turns the two channel bits into one enable per channel.
  function automatic logic [CH-1:0] chan_onehot(input logic [1:0] chan);
    logic [CH-1:0] hot;
    hot = '0;
    hot[chan] = 1'b1;
    return hot;
  endfunction : chan_onehot

  // Synchroniser edge test: a change counts once the second and third stages agree.
  function automatic logic sync_change(input logic [2:0] s, input logic seen);
    return (s[1] == s[2]) && (s[2] != seen);
  endfunction : sync_change

  // Bit counter; the frame's own select pin clears it, so a frame cut short leaves no trace.
  // The device reset clears it too, so the first frame after power-up counts from zero.
  always_ff @(negedge link_sclk_i or posedge sync_n_i or posedge rst_i) begin
    if (sync_n_i || rst_i) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != dqd_pkg::CNT_SAT) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // Shift register and captured word, sampled on the falling link clock edge.
  always_ff @(negedge link_sclk_i) begin
    if (!sync_n_i) begin
      shift_q <= {shift_q[dqd_pkg::FRAME_BITS-3:0], sdin_i};
      if (bit_cnt_q == dqd_pkg::LAST_PLAIN_BIT) begin
        word_q <= {shift_q, sdin_i};
      end
    end
  end

  // One toggle at the 24th bit and one at the 32nd; the check code bits themselves are dropped.
  // Reset clears both toggles at once. The link clock must be idle while reset is released,
  // which is why a host may not clock a frame during reset.
  always_ff @(negedge link_sclk_i or posedge rst_i) begin
    if (rst_i) begin
      plain_tgl_q <= 1'b0;
      pec_tgl_q <= 1'b0;
    end else begin
      if (!sync_n_i && bit_cnt_q == dqd_pkg::LAST_PLAIN_BIT) begin
        plain_tgl_q <= ~plain_tgl_q;
      end
      if (!sync_n_i && bit_cnt_q == dqd_pkg::LAST_PEC_BIT) begin
        pec_tgl_q <= ~pec_tgl_q;
      end
    end
  end

  // Toggle crossings into the system domain; reset zeroes them to match the cleared toggles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plain_sync_q <= '0;
      pec_sync_q <= '0;
    end else begin
      plain_sync_q <= {plain_sync_q[1:0], plain_tgl_q};
      pec_sync_q <= {pec_sync_q[1:0], pec_tgl_q};
    end
  end

  // Last seen toggle levels. Reset loads the same zero as the toggles, so no false frame
  // event follows the release of reset, even when reset cut a frame short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      plain_seen_q <= 1'b0;
      pec_seen_q <= 1'b0;
    end else begin
      if (plain_sync_q[1] == plain_sync_q[2]) begin
        plain_seen_q <= plain_sync_q[2];
      end
      if (pec_sync_q[1] == pec_sync_q[2]) begin
        pec_seen_q <= pec_sync_q[2];
      end
    end
  end

  // Pin synchronisers for the check mode, clear pin and address straps.
  always_ff @(posedge clk_i) begin
    pec_pin_q <= {pec_pin_q[1:0], pec_en_i};
    clr_pin_q <= {clr_pin_q[1:0], clear_i};
    strap_pin_q <= {strap_pin_q[1:0], {addr_strap_hi_i, addr_strap_lo_i}};
  end

  // Filtered pin levels; each follows its pin once the last two stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pec_mode_q <= 1'b0;
      clr_act_q <= 1'b0;
      strap_q <= 2'h0;
    end else begin
      if (pec_pin_q[1] == pec_pin_q[2]) begin
        pec_mode_q <= pec_pin_q[2];
      end
      if (clr_pin_q[1] == clr_pin_q[2]) begin
        clr_act_q <= clr_pin_q[2];
      end
      if (strap_pin_q[1] == strap_pin_q[2]) begin
        strap_q <= strap_pin_q[2];
      end
    end
  end

  // A frame is taken at its full length for the current mode; shorter frames never raise an event.
  assign plain_evt = sync_change(plain_sync_q, plain_seen_q);
  assign pec_evt = sync_change(pec_sync_q, pec_seen_q);
  assign frame_evt = !rst_i && (pec_mode_q ? pec_evt : plain_evt);

  // The captured word is stable for a whole frame after its toggle, so it is read directly.
  assign fr = dqd_pkg::dqd_frame_s'(word_q);
  assign addr_match = (fr.dev_addr == strap_q);
  assign wr_ok = frame_evt && addr_match && !fr.rw;
  assign chan_hot = chan_onehot(fr.chan);

  // Register-select decode; broadcasts ignore the channel bits.
  always_comb begin
    data_we = '0;
    gain_we = '0;
    offs_we = '0;
    clrv_we = '0;
    if (wr_ok) begin
      unique case (fr.reg_sel)
        dqd_pkg::SEL_DATA: data_we = chan_hot;
        dqd_pkg::SEL_GAIN: gain_we = chan_hot;
        dqd_pkg::SEL_GAIN_ALL: gain_we = '1;
        dqd_pkg::SEL_OFFS: offs_we = chan_hot;
        dqd_pkg::SEL_OFFS_ALL: offs_we = '1;
        dqd_pkg::SEL_CLEAR: clrv_we = chan_hot;
        default: begin
        end
      endcase
    end
  end

  // Clear is a level: while it stands, enabled channels keep reloading their clear value.
  assign force_en = {CH{clr_act_q}} & clr_en_q;

  // Per-channel clear enables come from the channel control payload.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_en_q <= '0;
    end else if (wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL && fr.payload[15:13] == dqd_pkg::CTL_CHAN) begin
      clr_en_q[fr.chan] <= fr.payload[dqd_pkg::CLR_EN_BIT];
    end
  end

  // Control writes are passed on as a one-cycle strobe with their decoded fields.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_wr_q <= 1'b0;
      ctrl_q <= '0;
    end else begin
      ctrl_wr_q <= wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL;
      if (wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL) begin
        ctrl_q.sel <= fr.payload[15:13];
        ctrl_q.chan <= fr.chan;
        ctrl_q.data <= fr.payload[dqd_pkg::CTRL_DATA_W-1:0];
      end
    end
  end

  // Output codes; the clear value is forced into channels with clear enabled while the clear pin is active.
  dqd_chan_bank #(.CH(CH), .W(W), .RST_VAL(dqd_pkg::DATA_RST)) u_data (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(data_we),
    .wr_data_i(fr.payload),
    .force_en_i(force_en),
    .force_data_i(clear_value_o),
    .q_o(chan_code_o)
  );

  // Gain trims, straight binary, full range writable.
  dqd_chan_bank #(.CH(CH), .W(W), .RST_VAL(dqd_pkg::GAIN_RST)) u_gain (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(gain_we),
    .wr_data_i(fr.payload),
    .force_en_i('0),
    .force_data_i('0),
    .q_o(gain_trim_o)
  );

  // Offset trims, offset binary around mid-code.
  dqd_chan_bank #(.CH(CH), .W(W), .RST_VAL(dqd_pkg::OFFSET_RST)) u_offs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(offs_we),
    .wr_data_i(fr.payload),
    .force_en_i('0),
    .force_data_i('0),
    .q_o(offset_trim_o)
  );

  // Clear values.
  dqd_chan_bank #(.CH(CH), .W(W), .RST_VAL(dqd_pkg::CLEAR_RST)) u_clrv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(clrv_we),
    .wr_data_i(fr.payload),
    .force_en_i('0),
    .force_data_i('0),
    .q_o(clear_value_o)
  );

  assign clear_en_o = clr_en_q;
  assign ctrl_wr_o = ctrl_wr_q;
  assign ctrl_o = ctrl_q;

  // Checks, all in the system clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Reset values are checked on the clock after each reset cycle, since the banks load them at a clock edge under reset.
  chk_gain_reset: assert property (disable iff (1'b0) rst_i |=>
    gain_trim_o[0] == 16'hffff && gain_trim_o[3] == 16'hffff)
    else $error("gain trim not ffff after reset");
  chk_offset_reset: assert property (disable iff (1'b0) rst_i |=>
    offset_trim_o[1] == 16'h8000 && offset_trim_o[2] == 16'h8000)
    else $error("offset trim not 8000 after reset");
  chk_clear_reset: assert property (disable iff (1'b0) rst_i |=>
    clear_value_o[0] == 16'h0000 && clear_value_o[3] == 16'h0000)
    else $error("clear value not zero after reset");

  chk_gain_broadcast: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_GAIN_ALL |=>
    gain_trim_o[0] == $past(fr.payload) && gain_trim_o[1] == $past(fr.payload)
    && gain_trim_o[2] == $past(fr.payload) && gain_trim_o[3] == $past(fr.payload))
    else $error("gain broadcast did not reach all channels");

  chk_offset_broadcast: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_OFFS_ALL |=>
    offset_trim_o[0] == $past(fr.payload) && offset_trim_o[3] == $past(fr.payload))
    else $error("offset broadcast did not reach all channels");

  chk_addr_filter: assert property (frame_evt && !addr_match |=>
    $stable(gain_trim_o) && $stable(offset_trim_o) && $stable(clear_value_o) && !ctrl_wr_o)
    else $error("frame for another address changed state");

  chk_ctrl_route: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL |=>
    ctrl_wr_o && ctrl_o.sel == $past(fr.payload[15:13]) ##1 !ctrl_wr_o)
    else $error("control write not passed on as one pulse");

  chk_ctrl_fields: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL |=>
    ctrl_o.chan == $past(fr.chan) && ctrl_o.data == $past(fr.payload[dqd_pkg::CTRL_DATA_W-1:0]))
    else $error("control write fields not passed on");

  chk_no_event_idle: assert property (!frame_evt |=>
    !ctrl_wr_o && $stable(gain_trim_o))
    else $error("state changed without a frame");

  // A read frame carries a payload too; it must never land in a register.
  chk_read_ignored: assert property (frame_evt && fr.rw |=>
    !ctrl_wr_o && $stable(gain_trim_o) && $stable(offset_trim_o) && $stable(clear_value_o))
    else $error("read frame changed state");

  // In check mode the 24th bit alone must never commit a write; only the 32nd may.
  chk_short_pec: assert property (pec_mode_q && plain_evt && !pec_evt |=>
    !ctrl_wr_o && $stable(gain_trim_o) && $stable(offset_trim_o) && $stable(clear_value_o))
    else $error("short frame committed in check mode");

  // Per-channel checks of single writes, clear enables and the clear force.
  for (genvar c = 0; c < CH; c++) begin : g_chk
    chk_data_single: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_DATA && !force_en[c] |=>
      chan_code_o[c] == ($past(fr.chan) == c ? $past(fr.payload) : $past(chan_code_o[c])))
      else $error("data write hit wrong channel");
    chk_gain_single: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_GAIN && fr.chan != c |=>
      $stable(gain_trim_o[c]))
      else $error("single gain write touched another channel");
    chk_offs_single: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_OFFS |=>
      offset_trim_o[c] == ($past(fr.chan) == c ? $past(fr.payload) : $past(offset_trim_o[c])))
      else $error("single offset write hit wrong channel");
    chk_clrv_single: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_CLEAR |=>
      clear_value_o[c] == ($past(fr.chan) == c ? $past(fr.payload) : $past(clear_value_o[c])))
      else $error("clear value write hit wrong channel");
    chk_clear_enable: assert property (wr_ok && fr.reg_sel == dqd_pkg::SEL_CTRL && fr.chan == c
      && fr.payload[15:13] == dqd_pkg::CTL_CHAN |=> clear_en_o[c] == $past(fr.payload[dqd_pkg::CLR_EN_BIT]))
      else $error("clear enable not taken from channel control write");
    chk_clear_force: assert property (clr_act_q && clr_en_q[c] |=>
      chan_code_o[c] == $past(clear_value_o[c]))
      else $error("enabled channel not forced to clear value");
    chk_clear_masked: assert property (clr_act_q && !clr_en_q[c] && data_we[c] == 1'b0 |=>
      $stable(chan_code_o[c]))
      else $error("disabled channel changed during clear");
  end

  // Main scenarios that a run is expected to reach.
  cov_data_write: cover property (wr_ok && fr.reg_sel == dqd_pkg::SEL_DATA);
  cov_gain_all: cover property (wr_ok && fr.reg_sel == dqd_pkg::SEL_GAIN_ALL);
  cov_pec_frame: cover property (pec_mode_q && frame_evt);
  cov_clear_force: cover property (clr_act_q && clr_en_q != '0);
  cov_ctrl_write: cover property (ctrl_wr_o);

endmodule : dqd_frame_decode

// >>> dv/dqd_host_model.sv
// Host side of the three-wire frame link: shifts the first n bits of a frame, MSB first.
`timescale 1ns/100ps
module dqd_host_model (
  // Serial link towards the decoder.
  output logic link_sclk_o,
  output logic sync_n_o,
  output logic sdin_o
);
  // The link clock idles high and stands still between frames.
  initial begin
    link_sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdin_o = 1'b0;
  end

  // Data changes after a rising edge so the falling edge samples it settled.
  task automatic send(input logic [31:0] w, input int n);
    #7;
    sync_n_o = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      sdin_o = w[i];
      #16 link_sclk_o = 1'b0;
      #16 link_sclk_o = 1'b1;
    end
    #16 sync_n_o = 1'b1;
    // A released data line shows the inverse of its last bit, not a held value.
    sdin_o = ~sdin_o;
    #40;
  endtask : send
  // The host writes any gain trim; keeping it near half-range is its own choice.
endmodule : dqd_host_model

// >>> dv/test_dqd_frame_decode.sv
// Self-checking bench for the frame decoder, driven through the host model.
`timescale 1ns/100ps
module test_dqd_frame_decode;
  localparam logic [1:0] ADR = 2'h2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic [1:0] strap = ADR;
  logic pec_en_i = 1'b0;
  logic clear_i = 1'b0;
  logic link_sclk, sync_n, sdin;
  logic [3:0][15:0] code_o, gain_o, offs_o, clrv_o;
  logic [3:0] clr_en_o;
  logic ctrl_wr_o;
  dqd_pkg::dqd_ctrl_s ctrl_o;
  logic [15:0] e_code [4];
  logic [15:0] e_gain [4];
  logic [15:0] e_offs [4];
  logic [15:0] e_clrv [4];
  logic e_en [4];
  logic [17:0] cap = 18'h0;
  int n_wr = 0;
  int n_errors = 0;
  int checks = 0;

  // The system clock runs free at 25 MHz.
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  dqd_host_model host (.link_sclk_o(link_sclk), .sync_n_o(sync_n), .sdin_o(sdin));

  dqd_frame_decode dut (
    .clk_i(clk_i), .rst_i(rst_i), .link_sclk_i(link_sclk), .sync_n_i(sync_n), .sdin_i(sdin),
    .pec_en_i(pec_en_i), .addr_strap_hi_i(strap[1]), .addr_strap_lo_i(strap[0]), .clear_i(clear_i),
    .chan_code_o(code_o), .gain_trim_o(gain_o), .offset_trim_o(offs_o), .clear_value_o(clrv_o),
    .clear_en_o(clr_en_o), .ctrl_wr_o(ctrl_wr_o), .ctrl_o(ctrl_o)
  );

  // Control pulses last one cycle; they are counted mid-cycle, where the pulse has settled.
  always @(negedge clk_i) begin
    if (ctrl_wr_o === 1'b1) begin
      cap <= ctrl_o;
      n_wr <= n_wr + 1;
    end
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Expected effect of one frame, worked out from the field layout.
  function automatic void apply(input logic [23:0] f, input int n);
    dqd_pkg::dqd_frame_s s;
    s = f;
    if (n < (pec_en_i ? 32 : 24) || s.rw || s.dev_addr != strap) return;
    case (s.reg_sel)
      3'h0: e_code[s.chan] = s.payload;
      3'h2: e_gain[s.chan] = s.payload;
      3'h3: for (int c = 0; c < 4; c++) e_gain[c] = s.payload;
      3'h4: e_offs[s.chan] = s.payload;
      3'h5: for (int c = 0; c < 4; c++) e_offs[c] = s.payload;
      3'h6: e_clrv[s.chan] = s.payload;
      3'h7: if (s.payload[15:13] == 3'h2) e_en[s.chan] = s.payload[2];
      default: ;
    endcase
  endfunction : apply

  task automatic check_all();
    for (int c = 0; c < 4; c++) begin
      check(code_o[c], e_code[c]);
      check(gain_o[c], e_gain[c]);
      check(offs_o[c], e_offs[c]);
      check(clrv_o[c], e_clrv[c]);
      check(clr_en_o[c], e_en[c]);
    end
  endtask : check_all

  task automatic send(input logic [23:0] f, input int n);
    host.send({f, 8'h3c}, n);
    apply(f, n);
    repeat (8) @(negedge clk_i);
    check_all();
  endtask : send

  function automatic logic [23:0] mk(input logic rw, input logic [1:0] a, input logic [2:0] sel,
                                     input logic [1:0] ch, input logic [15:0] p);
    return {rw, a, sel, ch, p};
  endfunction : mk

  // A hang counts as a mismatch and ends the run through the same verdict.
  initial begin
    #300000;
    n_errors++;
    give_verdict();
  end

  initial begin
    // Reset rises just after time zero so that its edge also clears the link side.
    #1;
    rst_i = 1'b1;
    for (int c = 0; c < 4; c++) begin
      e_code[c] = 16'h0000;
      e_gain[c] = 16'hffff;
      e_offs[c] = 16'h8000;
      e_clrv[c] = 16'h0000;
      e_en[c] = 1'b0;
    end
    // Reset is held long enough for the pin synchronisers to fill.
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check_all();
    check(ctrl_o, 18'h00000);
    for (int c = 0; c < 4; c++) send(mk(1'b0, ADR, 3'h0, c[1:0], 16'h1111 * (c + 1)), 24);
    send(mk(1'b0, ADR, 3'h2, 2'h2, 16'h1234), 24);
    send(mk(1'b0, ADR, 3'h3, 2'h1, 16'h7ffe), 24);
    send(mk(1'b0, ADR, 3'h2, 2'h0, 16'habcd), 24);
    send(mk(1'b0, ADR, 3'h4, 2'h3, 16'h0001), 24);
    send(mk(1'b0, ADR, 3'h5, 2'h0, 16'hfffe), 24);
    send(mk(1'b0, ADR, 3'h4, 2'h1, 16'h4321), 24);
    send(mk(1'b0, ADR, 3'h6, 2'h1, 16'ha5a5), 24);
    send(mk(1'b0, ADR, 3'h6, 2'h3, 16'h5a5a), 24);
    // Frames the decoder must drop without touching any register.
    send(mk(1'b0, ~ADR, 3'h0, 2'h0, 16'hdead), 24);
    send(mk(1'b1, ADR, 3'h0, 2'h0, 16'hbeef), 24);
    send(mk(1'b0, ADR, 3'h1, 2'h2, 16'h0f0f), 24);
    send(mk(1'b0, ADR, 3'h0, 2'h3, 16'hcafe), 23);
    // Every control group code is passed on as one pulse with its fields.
    for (int k = 0; k < 5; k++) begin
      send(mk(1'b0, ADR, 3'h7, k[1:0], {k[2:0], 13'h0ab0}), 24);
      check(n_wr, k + 1);
      check(cap, {k[2:0], k[1:0], 13'h0ab0});
    end
    send(mk(1'b0, ADR, 3'h7, 2'h1, 16'h4004), 24);
    send(mk(1'b0, ADR, 3'h7, 2'h3, 16'h4000), 24);
    check(n_wr, 7);
    check(cap, {3'h2, 2'h3, 13'h0000});
    // Clear forces only the enabled channel to its clear value.
    clear_i = 1'b1;
    repeat (8) @(negedge clk_i);
    for (int c = 0; c < 4; c++) if (e_en[c]) e_code[c] = e_clrv[c];
    check_all();
    clear_i = 1'b0;
    repeat (6) @(negedge clk_i);
    // With the check code on, a 24-bit frame is short and is dropped.
    pec_en_i = 1'b1;
    repeat (6) @(negedge clk_i);
    send(mk(1'b0, ADR, 3'h0, 2'h2, 16'h0bad), 24);
    send(mk(1'b0, ADR, 3'h0, 2'h2, 16'h600d), 32);
    // New strap levels move the device to another address; the old one is then foreign.
    strap = 2'h1;
    repeat (6) @(negedge clk_i);
    send(mk(1'b0, 2'h1, 3'h6, 2'h0, 16'h0c1e), 32);
    send(mk(1'b0, ADR, 3'h6, 2'h0, 16'h1dea), 32);
    give_verdict();
  end
endmodule : test_dqd_frame_decode
